// ===== hdl/tmc_pkg.sv
// Constants, field layout and mode type of the dual timer/counter mode control block.
// Assumes a single 50 MHz core clock and an AXI4-Lite register port with 8-bit byte addresses.

package tmc_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] TMC_ADDR_MODE = 8'h00;
	localparam logic [7:0] TMC_ADDR_CTRL = 8'h04;
	localparam logic [7:0] TMC_ADDR_CNT0 = 8'h08;
	localparam logic [7:0] TMC_ADDR_CNT1 = 8'h0C;
	localparam logic [7:0] TMC_ADDR_STAT = 8'h10;
	localparam logic [7:0] TMC_ADDR_MASK = 8'h14;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int TMC_FIELD1_LSB = 4;
	localparam int TMC_QUAL_BIT = 3;
	localparam int TMC_CSEL_BIT = 2;
	localparam int TMC_RUN0_BIT = 4;
	localparam int TMC_FLAG0_BIT = 5;
	localparam int TMC_RUN1_BIT = 6;
	localparam int TMC_FLAG1_BIT = 7;

	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic [7:0] TMC_MODE_RST = 8'h00;
	localparam logic [7:0] TMC_CNT_RST = 8'h00;
	localparam logic [1:0] TMC_STAT_RST = 2'h0;
	localparam logic [1:0] TMC_MASK_RST = 2'h0;
	localparam logic [3:0] TMC_TICK_DIV = 4'hC;
	localparam logic [3:0] TMC_TICK_LAST = TMC_TICK_DIV - 4'h1;

	// ****************************************
	// Bus answers and operating modes
	// ****************************************
	localparam logic [1:0] TMC_RESP_OKAY = 2'h0;
	localparam logic [1:0] TMC_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		TMC_MODE_13,
		TMC_MODE_16,
		TMC_MODE_RELOAD,
		TMC_MODE_SPLIT
	} tmc_mode_t;

endpackage : tmc_pkg

// ===== hdl/tmc_pin_sync.sv
// Two-stage synchronisers with falling-edge detection for the event and gate pins.
// Assumes the pins are asynchronous to aclk and change no faster than a few clock periods.

`timescale 1ns/1ps
`default_nettype none

module tmc_pin_sync #(
	parameter int N = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [N-1:0] pin,
	output logic [N-1:0] level,
	output logic [N-1:0] fall
);

	// ****************************************
	// Per-pin synchroniser
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_pin
			logic meta;
			logic prev;

			// The first stage feeds only the second; the edge is taken between the second and a third stage.
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					meta <= 1'b0;
					level[i] <= 1'b0;
					prev <= 1'b0;
					fall[i] <= 1'b0;
				end else begin
					meta <= pin[i];
					level[i] <= meta;
					prev <= level[i];
					fall[i] <= prev & ~level[i];
				end
			end
		end
	endgenerate

endmodule : tmc_pin_sync

`default_nettype wire

// ===== hdl/tmc_timer_top.sv
// Dual timer/counter with its mode register, run and overflow control, and an AXI4-Lite slave.
// Assumes one 50 MHz aclk, a synchronous active-low reset and asynchronous event and gate pins.

`timescale 1ns/1ps
`default_nettype none

module tmc_timer_top
	import tmc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic event_pin_zero,
	input wire logic event_pin_one,
	input wire logic ext_pin_zero,
	input wire logic ext_pin_one,
	input wire logic service_ack_zero,
	input wire logic service_ack_one,
	output logic overflow_flag_zero,
	output logic overflow_flag_one,
	output logic irq
);

	// ****************************************
	// Declarations
	// ****************************************
	logic [7:0] timer_mode_select;
	logic run_bit_zero;
	logic run_bit_one;
	logic [1:0] stat;
	logic [1:0] mask;
	logic [7:0] low_count_byte_zero;
	logic [7:0] high_count_byte_zero;
	logic [7:0] low_count_byte_one;
	logic [7:0] high_count_byte_one;
	logic [7:0] wr_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [3:0] tick_cnt;
	logic tick;
	logic [3:0] pin_level;
	logic [3:0] pin_fall;
	logic wr_go;
	logic wr_hit;
	logic mode_wr;
	logic ctrl_wr;
	logic cnt0_wr;
	logic cnt1_wr;
	logic stat_wr;
	logic mask_wr;
	logic [31:0] rd_data;
	logic rd_hit;
	tmc_mode_t mode_zero;
	tmc_mode_t mode_one;
	logic split;
	logic allow0;
	logic allow1;
	logic inc0;
	logic inc1;
	logic inc0_high;
	logic [16:0] step0;
	logic [16:0] step1;
	logic ovf_evt0;
	logic ovf_evt1;

	// One counting step of modes 0 to 2; returns overflow, new high byte and new low byte.
	function automatic logic [16:0] tmc_step(input tmc_mode_t m, input logic [7:0] tl, input logic [7:0] th);
		logic [13:0] s13;
		logic [16:0] s16;
		logic [8:0] s8;
		s13 = {1'b0, th, tl[4:0]} + 14'h0001;
		s16 = {1'b0, th, tl} + 17'h00001;
		s8 = {1'b0, tl} + 9'h001;
		tmc_step = {1'b0, th, tl};
		unique case (m)
			TMC_MODE_13: tmc_step = {s13[13], s13[12:5], tl[7:5], s13[4:0]};
			TMC_MODE_16: tmc_step = s16;
			TMC_MODE_RELOAD: tmc_step = {s8[8], th, (s8[8] ? th : s8[7:0])};
			TMC_MODE_SPLIT: tmc_step = {1'b0, th, tl};
		endcase
	endfunction : tmc_step

	// ****************************************
	// Pin synchronisers and internal tick
	// ****************************************
	tmc_pin_sync #(
		.N(4)
	) u_pin_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin({ext_pin_one, ext_pin_zero, event_pin_one, event_pin_zero}),
		.level(pin_level),
		.fall(pin_fall)
	);

	// Internal timer rate is one tick every TMC_TICK_DIV clocks.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt <= 4'h0;
			tick <= 1'b0;
		end else begin
			tick <= (tick_cnt == TMC_TICK_LAST);
			tick_cnt <= (tick_cnt == TMC_TICK_LAST) ? 4'h0 : tick_cnt + 4'h1;
		end
	end

	// ****************************************
	// AXI4-Lite write channel
	// ****************************************
	// Address and data are each held until both have arrived; the response follows both.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= TMC_RESP_OKAY;
			wr_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				wr_addr <= awaddr;
			end else if (bvalid && bready) begin
				awready <= 1'b1;
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				w_data <= wdata;
				w_strb <= wstrb;
			end else if (bvalid && bready) begin
				wready <= 1'b1;
			end
			if (wr_go) begin
				bvalid <= 1'b1;
				bresp <= wr_hit ? TMC_RESP_OKAY : TMC_RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Write decode; the low two address bits are ignored.
	always_comb begin
		wr_go = !awready && !wready && !bvalid;
		mode_wr = wr_go && ({wr_addr[7:2], 2'h0} == TMC_ADDR_MODE) && w_strb[0];
		ctrl_wr = wr_go && ({wr_addr[7:2], 2'h0} == TMC_ADDR_CTRL) && w_strb[0];
		cnt0_wr = wr_go && ({wr_addr[7:2], 2'h0} == TMC_ADDR_CNT0);
		cnt1_wr = wr_go && ({wr_addr[7:2], 2'h0} == TMC_ADDR_CNT1);
		stat_wr = wr_go && ({wr_addr[7:2], 2'h0} == TMC_ADDR_STAT) && w_strb[0];
		mask_wr = wr_go && ({wr_addr[7:2], 2'h0} == TMC_ADDR_MASK) && w_strb[0];
		wr_hit = (wr_addr[7:2] <= TMC_ADDR_MASK[7:2]);
	end

	// ****************************************
	// AXI4-Lite read channel
	// ****************************************
	// Read mux; reserved bits read as zero and unmapped offsets answer with an error.
	always_comb begin
		rd_data = 32'h00000000;
		rd_hit = 1'b1;
		unique case ({araddr[7:2], 2'h0})
			TMC_ADDR_MODE: rd_data[7:0] = timer_mode_select;
			TMC_ADDR_CTRL: rd_data[7:4] = {overflow_flag_one, run_bit_one, overflow_flag_zero, run_bit_zero};
			TMC_ADDR_CNT0: rd_data[15:0] = {high_count_byte_zero, low_count_byte_zero};
			TMC_ADDR_CNT1: rd_data[15:0] = {high_count_byte_one, low_count_byte_one};
			TMC_ADDR_STAT: rd_data[1:0] = stat;
			TMC_ADDR_MASK: rd_data[1:0] = mask;
			default: rd_hit = 1'b0;
		endcase
	end

	// One read under way at a time; data are captured at the address handshake.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= TMC_RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_data;
			rresp <= rd_hit ? TMC_RESP_OKAY : TMC_RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// ****************************************
	// Mode and control registers
	// ****************************************
	// Both fields are loaded together from one byte.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_mode_select <= TMC_MODE_RST;
		end else if (mode_wr) begin
			timer_mode_select <= w_data[7:0];
		end
	end

	// Run bits are software-owned and steer counting.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_bit_zero <= 1'b0;
			run_bit_one <= 1'b0;
		end else if (ctrl_wr) begin
			run_bit_zero <= w_data[TMC_RUN0_BIT];
			run_bit_one <= w_data[TMC_RUN1_BIT];
		end
	end

	// Overflow flags: an overflow in the same cycle as an acknowledge or a write still sets the flag.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			overflow_flag_zero <= 1'b0;
			overflow_flag_one <= 1'b0;
		end else begin
			overflow_flag_zero <= ovf_evt0 | (ctrl_wr ? w_data[TMC_FLAG0_BIT] : (overflow_flag_zero & ~service_ack_zero));
			overflow_flag_one <= ovf_evt1 | (ctrl_wr ? w_data[TMC_FLAG1_BIT] : (overflow_flag_one & ~service_ack_one));
		end
	end

	// ****************************************
	// Interrupt status, mask and output
	// ****************************************
	// Sticky status, cleared by writing one; a new event wins over the clear.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat <= TMC_STAT_RST;
			mask <= TMC_MASK_RST;
			irq <= 1'b0;
		end else begin
			stat <= {ovf_evt1, ovf_evt0} | (stat & ~(stat_wr ? w_data[1:0] : 2'h0));
			if (mask_wr) begin
				mask <= w_data[1:0];
			end
			irq <= |(stat & mask);
		end
	end

	// ****************************************
	// Counting control
	// ****************************************
	// Gating, clock source and mode selection for both timers.
	always_comb begin
		mode_zero = tmc_mode_t'(timer_mode_select[1:0]);
		mode_one = tmc_mode_t'(timer_mode_select[TMC_FIELD1_LSB+1:TMC_FIELD1_LSB]);
		split = (mode_zero == TMC_MODE_SPLIT);
		allow0 = run_bit_zero && (!timer_mode_select[TMC_QUAL_BIT] || pin_level[2]);
		allow1 = run_bit_one && (!timer_mode_select[TMC_FIELD1_LSB+TMC_QUAL_BIT] || pin_level[3]);
		inc0 = allow0 && (timer_mode_select[TMC_CSEL_BIT] ? pin_fall[0] : tick);
		inc1 = allow1 && (timer_mode_select[TMC_FIELD1_LSB+TMC_CSEL_BIT] ? pin_fall[1] : tick) &&
			(mode_one != TMC_MODE_SPLIT);
		inc0_high = split && run_bit_one && tick;
		step0 = tmc_step(mode_zero, low_count_byte_zero, high_count_byte_zero);
		step1 = tmc_step(mode_one, low_count_byte_one, high_count_byte_one);
		ovf_evt0 = inc0 && (split ? (low_count_byte_zero == 8'hFF) : step0[16]);
		ovf_evt1 = split ? (inc0_high && (high_count_byte_zero == 8'hFF)) : (inc1 && step1[16]);
	end

	// Timer zero counts; a software write to the count takes precedence over a step.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			low_count_byte_zero <= TMC_CNT_RST;
			high_count_byte_zero <= TMC_CNT_RST;
		end else if (cnt0_wr) begin
			if (w_strb[0]) begin
				low_count_byte_zero <= w_data[7:0];
			end
			if (w_strb[1]) begin
				high_count_byte_zero <= w_data[15:8];
			end
		end else if (split) begin
			if (inc0) begin
				low_count_byte_zero <= low_count_byte_zero + 8'h01;
			end
			if (inc0_high) begin
				high_count_byte_zero <= high_count_byte_zero + 8'h01;
			end
		end else if (inc0) begin
			{high_count_byte_zero, low_count_byte_zero} <= step0[15:0];
		end
	end

	// Timer one counts; it is frozen when its own mode field selects split.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			low_count_byte_one <= TMC_CNT_RST;
			high_count_byte_one <= TMC_CNT_RST;
		end else if (cnt1_wr) begin
			if (w_strb[0]) begin
				low_count_byte_one <= w_data[7:0];
			end
			if (w_strb[1]) begin
				high_count_byte_one <= w_data[15:8];
			end
		end else if (inc1) begin
			{high_count_byte_one, low_count_byte_one} <= step1[15:0];
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence seq_low0_full;
		inc0 && !cnt0_wr && (low_count_byte_zero == 8'hFF);
	endsequence

	sequence seq_high0_full;
		split && run_bit_one && tick && !cnt0_wr && (high_count_byte_zero == 8'hFF);
	endsequence

	gate_hold_a: assert property (!split && timer_mode_select[TMC_QUAL_BIT] && !pin_level[2] && !cnt0_wr
		|=> $stable({high_count_byte_zero, low_count_byte_zero}))
		else $error("timer zero moved while its gate pin was low");

	software_run_a: assert property ((mode_zero == TMC_MODE_16) && !timer_mode_select[TMC_QUAL_BIT] &&
		!timer_mode_select[TMC_CSEL_BIT] && run_bit_zero && tick && !cnt0_wr
		|=> {high_count_byte_zero, low_count_byte_zero} == $past({high_count_byte_zero, low_count_byte_zero}) + 16'h0001)
		else $error("timer zero did not step under software run");

	event_select_a: assert property ((mode_one == TMC_MODE_16) && timer_mode_select[TMC_FIELD1_LSB+TMC_CSEL_BIT] &&
		!pin_fall[1] && !cnt1_wr |=> $stable({high_count_byte_one, low_count_byte_one}))
		else $error("timer one counted without a pin event");

	reload_low_a: assert property ((mode_zero == TMC_MODE_RELOAD) and seq_low0_full
		|=> (low_count_byte_zero == $past(high_count_byte_zero)) && overflow_flag_zero)
		else $error("low byte not reloaded from high byte");

	mode13_wrap_a: assert property ((mode_zero == TMC_MODE_13) && inc0 && !cnt0_wr && (low_count_byte_zero[4:0] == 5'h1F) &&
		(high_count_byte_zero == 8'hFF) |=> overflow_flag_zero && (high_count_byte_zero == 8'h00))
		else $error("13-bit wrap did not overflow");

	split_low_a: assert property (split and seq_low0_full |=> (low_count_byte_zero == 8'h00) && overflow_flag_zero && stat[0])
		else $error("split low byte overflow lost");

	split_high_a: assert property (seq_high0_full |=> (high_count_byte_zero == 8'h00) && overflow_flag_one)
		else $error("split high byte did not set timer one flag");

	t1_stopped_a: assert property ((mode_one == TMC_MODE_SPLIT) && !cnt1_wr |=> $stable({high_count_byte_one, low_count_byte_one}))
		else $error("timer one counted in split mode");

	mode_layout_a: assert property (mode_wr |=> (timer_mode_select == $past(w_data[7:0])) &&
		(mode_one == tmc_mode_t'($past(w_data[5:4]))))
		else $error("mode register fields misplaced");

	flag_ack_a: assert property (overflow_flag_zero && service_ack_zero && !ovf_evt0 && !ctrl_wr |=> !overflow_flag_zero)
		else $error("acknowledge did not clear timer zero flag");

	irq_follow_a: assert property (|(stat & mask) |=> irq)
		else $error("unmasked status did not raise the interrupt");

endmodule : tmc_timer_top

`default_nettype wire

// ===== testbench/tmc_pin_model.sv
// Behavioural model of the event and gate pins that face the timer block.
// Assumes the bench calls its tasks from a process synchronised to aclk.
`timescale 1ns/1ps
`default_nettype none
module tmc_pin_model (
	input wire logic aclk,
	output var logic event_pin_zero,
	output var logic event_pin_one,
	output var logic ext_pin_zero,
	output var logic ext_pin_one
);
	// ****************************************
	// Pin drivers
	// ****************************************
	// All pins idle low so that the first event is a full high then low pulse.
	initial begin
		event_pin_zero = 1'b0;
		event_pin_one = 1'b0;
		ext_pin_zero = 1'b0;
		ext_pin_one = 1'b0;
	end

	// Each event holds three cycles high and four low, then leaves time for the synchronisers.
	task automatic pulse(input int which, input int n);
		repeat (n) begin
			@(posedge aclk);
			if (which == 0) event_pin_zero <= 1'b1; else event_pin_one <= 1'b1;
			repeat (3) @(posedge aclk);
			if (which == 0) event_pin_zero <= 1'b0; else event_pin_one <= 1'b0;
			repeat (3) @(posedge aclk);
		end
		repeat (6) @(posedge aclk);
	endtask : pulse

	// The gate is a plain level, changed just after a clock edge.
	task automatic gate(input int which, input logic v);
		@(posedge aclk);
		if (which == 0) ext_pin_zero <= v; else ext_pin_one <= v;
		repeat (4) @(posedge aclk);
	endtask : gate
endmodule : tmc_pin_model
`default_nettype wire

// ===== testbench/dual_timer_counter_mode_control_tb.sv
// Self-checking bench for the dual timer/counter with its AXI4-Lite register port.
// Assumes the pin model drives all pins and the bench acts as the bus master.
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_mode_control_tb import tmc_pkg::*;;
	// ****************************************
	// Signals and instances
	// ****************************************
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, ack0, ack1, fl0, fl1, irq;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	wire ev0, ev1, gt0, gt1;
	int bad_count, samples_checked;

	tmc_timer_top dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .event_pin_zero(ev0), .event_pin_one(ev1), .ext_pin_zero(gt0),
		.ext_pin_one(gt1), .service_ack_zero(ack0), .service_ack_one(ack1), .overflow_flag_zero(fl0),
		.overflow_flag_one(fl1), .irq(irq));
	tmc_pin_model pin_u (.aclk(aclk), .event_pin_zero(ev0), .event_pin_one(ev1), .ext_pin_zero(gt0),
		.ext_pin_one(gt1));

	// The 50 MHz clock.
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	// ****************************************
	// Bus, compare and closing tasks
	// ****************************************
	// Write address and data are offered together and each released at its own handshake.
	task automatic wr_r(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (aw || w) begin
			@(posedge aclk);
			if (aw && awready === 1'b1) begin aw = 1'b0; awvalid <= 1'b0; end
			if (w && wready === 1'b1) begin w = 1'b0; wvalid <= 1'b0; end
		end
		while (bvalid !== 1'b1) @(posedge aclk);
		resp = bresp;
		bready <= 1'b0;
	endtask : wr_r

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge aclk);
		v = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [1:0] resp;
		wr_r(a, v, resp);
		chk("write resp", {30'h0, TMC_RESP_OKAY}, {30'h0, resp});
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
		logic [31:0] v;
		logic [1:0] resp;
		rd(a, v, resp);
		chk(n, e, v);
		chk("read resp", {30'h0, TMC_RESP_OKAY}, {30'h0, resp});
	endtask : rc

	task automatic ack(input int which);
		@(posedge aclk);
		if (which == 0) ack0 <= 1'b1; else ack1 <= 1'b1;
		@(posedge aclk);
		ack0 <= 1'b0;
		ack1 <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask : ack

	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		rc(TMC_ADDR_MODE, 32'h0, "mode");
		rc(TMC_ADDR_CTRL, 32'h0, "ctrl");
		rc(TMC_ADDR_CNT0, 32'h0, "count0");
		rc(TMC_ADDR_CNT1, 32'h0, "count1");
		rc(TMC_ADDR_STAT, 32'h0, "status");
		rd(8'h18, d, r);
		chk("unmapped read", {30'h0, TMC_RESP_SLVERR}, {30'h0, r});
		chk("unmapped data", 32'h0, d);
		wr_r(8'h18, 32'hFF, r);
		chk("unmapped write", {30'h0, TMC_RESP_SLVERR}, {30'h0, r});
		$display("reset test done");
	endtask : t_reset

	// Gated timer zero with the gate low beside timer one as an event counter, in one write.
	task automatic t_both;
		wr(TMC_ADDR_MODE, 32'h69);
		rc(TMC_ADDR_MODE, 32'h69, "mode both");
		wr(TMC_ADDR_CTRL, 32'h50);
		repeat (40) @(posedge aclk);
		pin_u.pulse(1, 2);
		wr(TMC_ADDR_CTRL, 32'h0);
		rc(TMC_ADDR_CNT0, 32'h0, "gated count0");
		rc(TMC_ADDR_CNT1, 32'h2, "events count1");
		$display("both timers test done");
	endtask : t_both

	task automatic t_gate;
		wr(TMC_ADDR_CNT0, 32'h0);
		wr(TMC_ADDR_MODE, 32'h0D);
		wr(TMC_ADDR_CTRL, 32'h10);
		pin_u.pulse(0, 3);
		rc(TMC_ADDR_CNT0, 32'h0, "gate low");
		pin_u.gate(0, 1'b1);
		pin_u.pulse(0, 3);
		rc(TMC_ADDR_CNT0, 32'h3, "gate high");
		pin_u.gate(0, 1'b0);
		wr(TMC_ADDR_MODE, 32'h05);
		pin_u.pulse(0, 2);
		rc(TMC_ADDR_CNT0, 32'h5, "no qualify");
		wr(TMC_ADDR_CTRL, 32'h0);
		pin_u.pulse(0, 2);
		rc(TMC_ADDR_CNT0, 32'h5, "run off");
		wr(TMC_ADDR_MODE, 32'hD0);
		wr(TMC_ADDR_CNT1, 32'h0);
		wr(TMC_ADDR_CTRL, 32'h40);
		pin_u.pulse(1, 2);
		rc(TMC_ADDR_CNT1, 32'h0, "gate1 low");
		pin_u.gate(1, 1'b1);
		pin_u.pulse(1, 2);
		rc(TMC_ADDR_CNT1, 32'h2, "gate1 high");
		pin_u.gate(1, 1'b0);
		wr(TMC_ADDR_CTRL, 32'h0);
		$display("gate test done");
	endtask : t_gate

	// Sixteen-bit wrap sets the flag, status and interrupt, then each is cleared.
	task automatic t_ovf;
		int n;
		wr(TMC_ADDR_CNT0, 32'hFFFF);
		wr(TMC_ADDR_MODE, 32'h01);
		wr(TMC_ADDR_MASK, 32'h1);
		chk("flag before run", 32'h0, {31'h0, fl0});
		wr(TMC_ADDR_CTRL, 32'h10);
		n = 0;
		while (fl0 !== 1'b1 && n < 60) begin @(posedge aclk); n++; end
		repeat (2) @(posedge aclk);
		chk("flag0 set", 32'h1, {31'h0, fl0});
		chk("irq set", 32'h1, {31'h0, irq});
		rc(TMC_ADDR_STAT, 32'h1, "status set");
		ack(0);
		chk("flag0 acked", 32'h0, {31'h0, fl0});
		wr(TMC_ADDR_STAT, 32'h1);
		repeat (2) @(posedge aclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		wr(TMC_ADDR_MASK, 32'h0);
		wr(TMC_ADDR_CTRL, 32'h0);
		$display("overflow test done");
	endtask : t_ovf

	task automatic t_modes;
		wr(TMC_ADDR_MODE, 32'h04);
		wr(TMC_ADDR_CNT0, 32'h12FF);
		wr(TMC_ADDR_CTRL, 32'h10);
		pin_u.pulse(0, 1);
		rc(TMC_ADDR_CNT0, 32'h13E0, "13-bit carry");
		wr(TMC_ADDR_CNT0, 32'hFFFF);
		pin_u.pulse(0, 1);
		rc(TMC_ADDR_CNT0, 32'h00E0, "13-bit wrap");
		chk("wrap flag", 32'h1, {31'h0, fl0});
		wr(TMC_ADDR_CTRL, 32'h10);
		wr(TMC_ADDR_MODE, 32'h06);
		wr(TMC_ADDR_CNT0, 32'hF0FE);
		pin_u.pulse(0, 2);
		rc(TMC_ADDR_CNT0, 32'hF0F0, "reload");
		chk("reload flag", 32'h1, {31'h0, fl0});
		wr(TMC_ADDR_CTRL, 32'h0);
		$display("mode test done");
	endtask : t_modes

	task automatic t_split;
		logic [1:0] rr;
		logic [31:0] h;
		wr(TMC_ADDR_CNT1, 32'h0);
		wr(TMC_ADDR_CNT0, 32'hFFFE);
		wr(TMC_ADDR_MODE, 32'h37);
		wr(TMC_ADDR_CTRL, 32'h50);
		pin_u.pulse(0, 2);
		repeat (30) @(posedge aclk);
		rd(TMC_ADDR_CNT0, d, r);
		chk("split low", 32'h0, {24'h0, d[7:0]});
		chk("split flag0", 32'h1, {31'h0, fl0});
		chk("split flag1", 32'h1, {31'h0, fl1});
		rc(TMC_ADDR_CNT1, 32'h0, "timer1 held");
		ack(1);
		chk("flag1 acked", 32'h0, {31'h0, fl1});
		wr(TMC_ADDR_CTRL, 32'h10);
		rd(TMC_ADDR_CNT0, h, rr);
		repeat (40) @(posedge aclk);
		rd(TMC_ADDR_CNT0, d, r);
		chk("high byte idle", {24'h0, h[15:8]}, {24'h0, d[15:8]});
		wr(TMC_ADDR_CTRL, 32'h0);
		$display("split test done");
	endtask : t_split

	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, ack0, ack1} = 8'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'h0;
		bad_count = 0;
		samples_checked = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_both();
		t_gate();
		t_ovf();
		t_modes();
		t_split();
		finish_test();
	end

	// A hang well past the expected few hundred cycles counts as a mismatch.
	initial begin
		#400000;
		bad_count++;
		finish_test();
	end
endmodule : dual_timer_counter_mode_control_tb
`default_nettype wire
